// file: core/rst_seq_consts.svh
/*
  Timing counts, counter and cause widths, and reset-cause bit positions for the reset sequencer.
  Assumes it is included by its bare name from files under core/ and tb/.
*/
`ifndef RST_SEQ_CONSTS_SVH
`define RST_SEQ_CONSTS_SVH
`define SELF_CLK_MHZ      100
`define DRIVE_LOW_CYCLES  34
`define SAMPLE_WAIT_CYCLES 38
`define CNT_W             6
`define CAUSE_W           4
`define CAUSE_POR         0
`define CAUSE_PIN         1
`define CAUSE_LVD         2
`define CAUSE_WDOG        3
`define BIT_CYCLES        16
`endif

// file: core/rst_seq_pkg.sv
/*
  Types shared by the reset sequencer modules.
  Assumes the constants header is compiled alongside.
*/
package rst_seq_pkg;
  typedef enum logic [2:0] {
    ST_POR     = 3'b000,
    ST_DRIVE   = 3'b001,
    ST_WAIT    = 3'b011,
    ST_RUN     = 3'b010
  } seq_state_t;
endpackage

// file: core/sync_if.sv
/*
  Interface carrying raw pin levels into the synchroniser and clean levels out.
  Assumes one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
interface sync_if;
  logic raw_rst_pin;
  logic raw_mode_pin;
  logic sync_rst_pin;
  logic sync_mode_pin;
  modport src (output raw_rst_pin, output raw_mode_pin, input sync_rst_pin, input sync_mode_pin);
  modport snk (input raw_rst_pin, input raw_mode_pin, output sync_rst_pin, output sync_mode_pin);
endinterface
`default_nettype wire

// file: core/pin_sync.sv
/*
  Two-stage synchroniser for the reset pin and the debug/mode pin.
  Assumes core_clk is the self-clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input wire logic core_clk,  // Self-clock
  input wire logic rst_n,     // Synchronous reset, active low
  sync_if.snk      sif        // Raw in, clean out
);
  logic [1:0] s1_reg, s1_next;
  logic [1:0] s2_reg, s2_next;

  // Stage one feeds only stage two
  always_comb begin
    s1_next = {sif.raw_mode_pin, sif.raw_rst_pin};
    s2_next = s1_reg;
  end

  // Pullups make idle high the safe reset value
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s1_reg <= 2'h3;
      s2_reg <= 2'h3;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
    end
  end

  assign sif.sync_rst_pin  = s2_reg[0];
  assign sif.sync_mode_pin = s2_reg[1];
endmodule
`default_nettype wire

// file: core/reset_pin_and_mode_select.sv
/*
  Reset pin sequencer, reset cause capture and mode select at reset release.
  Assumes core_clk is the internal self-clock; the two pin inputs are synchronised here, all other inputs are synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rst_seq_consts.svh"
module reset_pin_and_mode_select
  import rst_seq_pkg::*;
(
  input  wire logic                core_clk,       // Self-clock, 100 MHz
  input  wire logic                rst_n,          // Power-on reset, active low
  input  wire logic                lvd_req,        // Low-voltage reset request
  input  wire logic                wdog_req,       // Watchdog reset request
  input  wire logic                reset_pin_in,   // Reset pin level
  output logic                     reset_pin_out,  // Reset pin drive value
  output logic                     reset_pin_oe_n, // Reset pin enable, low drives
  input  wire logic                debug_mode_pin_in, // Debug/mode pin level
  input  wire logic                port_bit_sel,   // Pin used as port bit
  input  wire logic                port_bit_val,   // Port bit output value
  input  wire logic                dbg_drive,      // Debug controller drives pin
  input  wire logic                dbg_val,        // Debug controller drive value
  output logic                     debug_mode_pin_out,  // Debug pin drive value
  output logic                     debug_mode_pin_oe_n, // Debug pin enable, low drives
  input  wire logic                stop_self_clk_sel,   // Software picks self-clock for stop
  output logic                     stop_clk_self,  // Stop recovery uses self-clock
  input  wire logic                irq_enable_set, // Software enables interrupt pin
  output logic                     irq_pin_enabled, // Interrupt input enabled
  output logic                     in_reset,       // Core held in reset
  output logic                     bkgd_mode,      // Active background mode
  output logic                     sample_mismatch, // Internal cause but pin read low
  output logic [`CAUSE_W-1:0]      reset_cause_register // Reset cause bits
);
  // Both pin inputs go through the synchroniser before any decision is taken
  sync_if sif();
  pin_sync u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .sif      (sif)
  );
  assign sif.raw_rst_pin  = reset_pin_in;
  assign sif.raw_mode_pin = debug_mode_pin_in;

  seq_state_t                st_reg, st_next;
  logic [`CNT_W-1:0]         cnt_reg, cnt_next;
  logic [`CAUSE_W-1:0]       cause_reg, cause_next;
  logic                      internal_reg, internal_next;
  logic                      drv_reg, drv_next;
  logic                      inrst_reg, inrst_next;
  logic                      bkgd_reg, bkgd_next;
  logic                      mism_reg, mism_next;
  logic                      irq_en_reg, irq_en_next;
  logic                      stopsel_reg, stopsel_next;
  logic                      dout_reg, dout_next;
  logic                      doe_n_reg, doe_n_next;

  // Counter end test, shared by the drive and the wait phase
  function automatic logic cnt_at_end(
    input logic [`CNT_W-1:0] cnt,   // Running count
    input logic [`CNT_W-1:0] last   // Last count of the phase
  );
    cnt_at_end = (cnt == last);
  endfunction

  // Cause vector of a new reset; with no internal request the pin did it
  function automatic logic [`CAUSE_W-1:0] cause_decode(
    input logic lvd,   // Low-voltage request
    input logic wdog   // Watchdog request
  );
    cause_decode              = '0;
    cause_decode[`CAUSE_LVD]  = lvd;
    cause_decode[`CAUSE_WDOG] = wdog;
    cause_decode[`CAUSE_PIN]  = ~(lvd | wdog);
  endfunction

  // Sequencer, cause capture and mode latch
  always_comb begin
    st_next       = st_reg;
    cnt_next      = cnt_reg;
    cause_next    = cause_reg;
    internal_next = internal_reg;
    drv_next      = drv_reg;
    inrst_next    = inrst_reg;
    bkgd_next     = bkgd_reg;
    mism_next     = mism_reg;
    // Software cannot run in reset, so an enable seen there is ignored
    irq_en_next   = irq_en_reg | (irq_enable_set & ~inrst_reg);
    stopsel_next  = stop_self_clk_sel;
    case (st_reg)
      ST_POR: begin
        st_next    = ST_DRIVE;
        cnt_next   = '0;
        drv_next   = 1'b1;
        inrst_next = 1'b1;
      end
      ST_DRIVE: begin
        if (cnt_at_end(cnt_reg, `CNT_W'(`DRIVE_LOW_CYCLES - 1))) begin
          st_next  = ST_WAIT;
          cnt_next = '0;
          drv_next = 1'b0;
        end else begin
          cnt_next = cnt_reg + `CNT_W'(1);
        end
      end
      ST_WAIT: begin
        // A low sample repeats the whole wait; an outside hold keeps the core in reset
        if (cnt_at_end(cnt_reg, `CNT_W'(`SAMPLE_WAIT_CYCLES - 1))) begin
          cnt_next = '0;
          if (sif.sync_rst_pin) begin
            st_next    = ST_RUN;
            inrst_next = 1'b0;
            bkgd_next  = ~sif.sync_mode_pin;
          end else if (internal_reg) begin
            mism_next  = 1'b1;
          end else begin
            cause_next = cause_reg | cause_decode(1'b0, 1'b0);
          end
        end else begin
          cnt_next = cnt_reg + `CNT_W'(1);
        end
      end
      ST_RUN: begin
        // Requests are taken only while running; during a sequence they are dropped
        if (lvd_req || wdog_req || !sif.sync_rst_pin) begin
          st_next       = ST_DRIVE;
          cnt_next      = '0;
          drv_next      = 1'b1;
          inrst_next    = 1'b1;
          mism_next     = 1'b0;
          irq_en_next   = 1'b0;
          internal_next = lvd_req | wdog_req;
          // New reset replaces the previous cause record
          cause_next    = cause_decode(lvd_req, wdog_req);
        end
      end
      default: begin
        st_next = ST_POR;
      end
    endcase
  end

  // Debug pin drive; released in reset so the host's mode level can be read
  always_comb begin
    // Port bit mode forbids input use; debug role only after reset
    if (inrst_reg) begin
      dout_next  = 1'b1;
      doe_n_next = 1'b1;
    end else if (port_bit_sel) begin
      dout_next  = port_bit_val;
      doe_n_next = 1'b0;
    end else begin
      dout_next  = dbg_val;
      doe_n_next = ~dbg_drive;
    end
  end

  // Pin drive registers; the pull-up level is the safe reset value
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dout_reg  <= 1'b1;
      doe_n_reg <= 1'b1;
    end else begin
      dout_reg  <= dout_next;
      doe_n_reg <= doe_n_next;
    end
  end

  // Registers; power-on cause set at reset, self-clock runs throughout
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_reg       <= ST_POR;
      cnt_reg      <= '0;
      cause_reg    <= `CAUSE_W'(1) << `CAUSE_POR;
      internal_reg <= 1'b1;
      drv_reg      <= 1'b1;
      inrst_reg    <= 1'b1;
      bkgd_reg     <= 1'b0;
      mism_reg     <= 1'b0;
      irq_en_reg   <= 1'b0;
      stopsel_reg  <= 1'b0;
    end else begin
      st_reg       <= st_next;
      cnt_reg      <= cnt_next;
      cause_reg    <= cause_next;
      internal_reg <= internal_next;
      drv_reg      <= drv_next;
      inrst_reg    <= inrst_next;
      bkgd_reg     <= bkgd_next;
      mism_reg     <= mism_next;
      irq_en_reg   <= irq_en_next;
      stopsel_reg  <= stopsel_next;
    end
  end

  // Reset pin only ever pulls low
  assign reset_pin_out        = 1'b0;
  assign reset_pin_oe_n       = ~drv_reg;
  assign debug_mode_pin_out   = dout_reg;
  assign debug_mode_pin_oe_n  = doe_n_reg;
  assign stop_clk_self        = stopsel_reg;
  assign irq_pin_enabled      = irq_en_reg;
  assign in_reset             = inrst_reg;
  assign bkgd_mode            = bkgd_reg;
  assign sample_mismatch      = mism_reg;
  assign reset_cause_register = cause_reg;
endmodule
`default_nettype wire

// file: tb/rst_seq_monitor.sv
/* Port checker for the reset sequencer.
   Assumes one clock domain; bound to the top module below. */
`timescale 1ns/1ps
`default_nettype none
`include "rst_seq_consts.svh"
module rst_seq_monitor (
  input wire logic               core_clk,            // Clock
  input wire logic               rst_n,               // Reset
  input wire logic               lvd_req,             // Low-voltage request
  input wire logic               wdog_req,            // Watchdog request
  input wire logic               reset_pin_in,        // Reset pin
  input wire logic               reset_pin_oe_n,      // Reset drive
  input wire logic               debug_mode_pin_in,   // Mode pin
  input wire logic               debug_mode_pin_out,  // Mode drive value
  input wire logic               debug_mode_pin_oe_n, // Mode drive
  input wire logic               port_bit_sel,        // Port use
  input wire logic               port_bit_val,        // Port value
  input wire logic               dbg_drive,           // Debug drive
  input wire logic               irq_pin_enabled,     // Interrupt enable
  input wire logic               in_reset,            // In reset
  input wire logic               bkgd_mode,           // Background mode
  input wire logic [`CAUSE_W-1:0] reset_cause_register // Causes
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Internal request taken only while running
  wire logic start = !in_reset && (lvd_req || wdog_req);
  // Bounds are the counts less one, since the first cycle is the anchor
  sequence s_drive; !reset_pin_oe_n throughout (1'b1 ##33 1'b1); endsequence
  sequence s_wait; (reset_pin_oe_n && in_reset) throughout (1'b1 ##37 1'b1); endsequence
  a_drive_then_wait: assert property (start |=> s_drive ##1 s_wait)
    else $error("reset drive or wait length wrong");
  a_cause_bits: assert property (start |=>
    reset_cause_register[`CAUSE_LVD] == $past(lvd_req)
    && reset_cause_register[`CAUSE_WDOG] == $past(wdog_req)) else $error("cause bits wrong");
  a_ext_reset: assert property ((!in_reset && !reset_pin_in) |-> ##[1:3] in_reset)
    else $error("held reset pin ignored");
  a_mode_select: assert property ($fell(in_reset)
    && debug_mode_pin_in == $past(debug_mode_pin_in, 5) |-> bkgd_mode == !debug_mode_pin_in)
    else $error("mode picked wrongly");
  a_mode_hold: assert property (!in_reset && !$past(in_reset) |-> $stable(bkgd_mode))
    else $error("mode changed while running");
  a_cause_hold: assert property (!in_reset && !$past(in_reset) |-> $stable(reset_cause_register))
    else $error("causes changed while running");
  a_pins_in_reset: assert property (in_reset && $past(in_reset)
    |-> debug_mode_pin_oe_n && !irq_pin_enabled) else $error("pin or interrupt active in reset");
  a_port_output: assert property (port_bit_sel && !dbg_drive && !in_reset |=> in_reset
    || (!debug_mode_pin_oe_n && debug_mode_pin_out == $past(port_bit_val)))
    else $error("port bit not driven");
endmodule
bind reset_pin_and_mode_select rst_seq_monitor mon (.core_clk, .rst_n, .lvd_req, .wdog_req,
  .reset_pin_in, .reset_pin_oe_n, .debug_mode_pin_in, .debug_mode_pin_out, .debug_mode_pin_oe_n,
  .port_bit_sel, .port_bit_val, .dbg_drive, .irq_pin_enabled, .in_reset, .bkgd_mode,
  .reset_cause_register);
`default_nettype wire

// file: tb/pin_partner.sv
/* Far side: external reset source and debug host on the two pins.
   Assumes both pins carry pull-ups and enables are low while driving. */
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  input  wire logic ext_rst_req,         // Source pulls reset low
  input  wire logic host_mode_low,       // Host holds mode pin low
  input  wire logic reset_pin_oe_n,      // Device reset drive
  input  wire logic reset_pin_out,       // Device reset value
  input  wire logic debug_mode_pin_oe_n, // Device mode drive
  input  wire logic debug_mode_pin_out,  // Device mode value
  output logic      reset_pin_in,        // Resolved reset pin
  output logic      debug_mode_pin_in    // Resolved mode pin
);
  // Wired levels; the pull-up wins only when nobody pulls low
  assign reset_pin_in = !ext_rst_req && (reset_pin_oe_n || reset_pin_out);
  assign debug_mode_pin_in = !host_mode_low && (debug_mode_pin_oe_n || debug_mode_pin_out);
endmodule
`default_nettype wire

// file: tb/reset_pin_and_mode_select_tb.sv
/* Self-checking bench for the reset sequencer.
   Assumes the partner resolves both pins and the checker is bound. */
`timescale 1ns/1ps
`default_nettype none
`include "rst_seq_consts.svh"
module reset_pin_and_mode_select_tb;
  logic core_clk, rst_n, lvd_req, wdog_req, reset_pin_in, reset_pin_out, reset_pin_oe_n, rv;
  logic debug_mode_pin_in, port_bit_sel, port_bit_val, dbg_drive, dbg_val, debug_mode_pin_out;
  logic debug_mode_pin_oe_n, stop_self_clk_sel, stop_clk_self, irq_enable_set, irq_pin_enabled;
  logic in_reset, bkgd_mode, sample_mismatch, ext_rst_req, host_mode_low;
  logic [`CAUSE_W-1:0] reset_cause_register;
  int miscompares, check_count, lo, hi, seed, kinds[3], exp_q[$];
  reset_pin_and_mode_select dut (.core_clk, .rst_n, .lvd_req, .wdog_req, .reset_pin_in,
    .reset_pin_out, .reset_pin_oe_n, .debug_mode_pin_in, .port_bit_sel, .port_bit_val,
    .dbg_drive, .dbg_val, .debug_mode_pin_out, .debug_mode_pin_oe_n, .stop_self_clk_sel,
    .stop_clk_self, .irq_enable_set, .irq_pin_enabled, .in_reset, .bkgd_mode,
    .sample_mismatch, .reset_cause_register);
  pin_partner far (.ext_rst_req, .host_mode_low, .reset_pin_oe_n, .reset_pin_out,
    .debug_mode_pin_oe_n, .debug_mode_pin_out, .reset_pin_in, .debug_mode_pin_in);
  // Self-clock, 10 ns period
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task close_out;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task tick;
    @(posedge core_clk);
    #1;
  endtask
  // Drive length, then wait length; a sequence that never ends is a failure
  task measure;
    lo = 0;
    hi = 0;
    #1;
    for (int i = 0; i < 9 && reset_pin_oe_n !== 1'b0; i++) tick;
    while (reset_pin_oe_n === 1'b0 && lo < 300) begin lo++; tick; end
    while (in_reset === 1'b1 && hi < 300) begin hi++; tick; end
    if (hi >= 300) begin miscompares++; close_out; end
  endtask
  initial begin
    seed = 32'h4b82;
    kinds = '{`CAUSE_LVD, `CAUSE_WDOG, `CAUSE_PIN};
    {rst_n, lvd_req, wdog_req, port_bit_sel, port_bit_val, dbg_drive, dbg_val} = '0;
    {stop_self_clk_sel, irq_enable_set, ext_rst_req, host_mode_low} = '0;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    exp_q.push_back(1 << `CAUSE_POR);
    measure;
    chk(hi, `SAMPLE_WAIT_CYCLES);
    chk(reset_cause_register, exp_q.pop_front());
    chk(bkgd_mode, 0);
    $display("power-on test done");
    // Low-voltage, watchdog and pin causes, alternating the mode pin level across the release
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk) begin host_mode_low <= i[0]; irq_enable_set <= 1'b1; end
      @(posedge core_clk) irq_enable_set <= 1'b0;
      tick;
      chk(irq_pin_enabled, 1);
      @(posedge core_clk) begin
        lvd_req <= (kinds[i] == `CAUSE_LVD);
        wdog_req <= (kinds[i] == `CAUSE_WDOG);
        ext_rst_req <= (kinds[i] == `CAUSE_PIN);
        exp_q.push_back(1 << kinds[i]);
      end
      @(posedge core_clk) {lvd_req, wdog_req, ext_rst_req} <= 3'b000;
      measure;
      chk(lo, `DRIVE_LOW_CYCLES);
      chk(hi, `SAMPLE_WAIT_CYCLES);
      chk(reset_cause_register, exp_q.pop_front());
      chk(bkgd_mode, i[0]);
      chk(irq_pin_enabled, 0);
      chk(sample_mismatch, 0);
      @(posedge core_clk) host_mode_low <= 1'b0;
      $display("cause %0d test done", kinds[i]);
    end
    // Random port bits with stop-clock picks, then debug drive with random values
    for (int n = 0; n < 12; n++) begin
      @(posedge core_clk) begin
        rv = 1'($random(seed));
        {port_bit_sel, dbg_drive} <= {n < 8, n >= 8};
        {port_bit_val, dbg_val, stop_self_clk_sel} <= {rv, rv, !rv};
      end
      tick;
      chk(debug_mode_pin_oe_n, 0);
      chk(debug_mode_pin_out, rv);
      chk(stop_clk_self, !rv);
    end
    $display("pin drive test done");
    // Internal cause while the pin is held low outside: the sample must fail
    @(posedge core_clk) begin lvd_req <= 1'b1; ext_rst_req <= 1'b1; dbg_drive <= 1'b0; end
    @(posedge core_clk) lvd_req <= 1'b0;
    exp_q.push_back(1 << `CAUSE_LVD);
    repeat (80) tick;
    chk(in_reset, 1);
    chk(sample_mismatch, 1);
    @(posedge core_clk) ext_rst_req <= 1'b0;
    measure;
    chk(reset_cause_register, exp_q.pop_front());
    $display("held pin test done");
    // Mid-run power-on reset must clear the mismatch flag and the interrupt enable
    @(posedge core_clk) irq_enable_set <= 1'b1;
    @(posedge core_clk) begin irq_enable_set <= 1'b0; rst_n <= 1'b0; end
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    exp_q.push_back(1 << `CAUSE_POR);
    measure;
    chk(hi, `SAMPLE_WAIT_CYCLES);
    chk(reset_cause_register, exp_q.pop_front());
    chk(sample_mismatch, 0);
    chk(irq_pin_enabled, 0);
    chk(bkgd_mode, 0);
    $display("mid-run reset test done");
    close_out;
  end
endmodule
`default_nettype wire
